// file: design/tlic_ctrl.v
`timescale 1ns/100ps
`default_nettype none

`include "tlic_regs.vh"

module tlic_ctrl (
  input wire clk,
  input wire rstn,
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire [7:0] sfr_wdata,
  input wire sfr_rd,
  output reg [7:0] sfr_rdata,
  input wire sfr_bit_wr,
  input wire [7:0] sfr_bit_addr,
  input wire sfr_bit_wdata,
  input wire src_psm_req,
  input wire src_wdog_req,
  input wire src_ext0_req,
  input wire src_adc_req,
  input wire src_timer0_req,
  input wire src_ext1_req,
  input wire src_timer1_req,
  input wire src_spi_req,
  input wire src_uart_req,
  input wire src_timer2_req,
  input wire src_tic_req,
  input wire irq_ack,
  input wire irq_return,
  output reg irq_valid,
  output reg [15:0] irq_vector,
  output reg irq_level,
  output reg [3:0] irq_source,
  output reg active_high,
  output reg active_low
);

  reg [7:0] interrupt_enable_primary;
  reg [7:0] interrupt_enable_priority_secondary;
  reg [7:0] interrupt_priority_primary;
  reg [7:0] next_enable_primary;
  reg [7:0] next_enable_priority_secondary;
  reg [7:0] next_priority_primary;
  reg [7:0] next_rdata;
  reg next_valid;
  reg [15:0] next_vector;
  reg next_level;
  reg [3:0] next_source;
  reg next_active_high;
  reg next_active_low;

  wire [`TLIC_NUM_SRC-1:0] req_in;
  wire [`TLIC_NUM_SRC-1:0] src_enable;
  wire [`TLIC_NUM_SRC-1:0] src_high;
  wire [`TLIC_NUM_SRC-1:0] pending;
  wire [`TLIC_NUM_SRC-1:0] cand_high;
  wire [`TLIC_NUM_SRC-1:0] cand_low;
  wire found_high;
  wire found_low;
  wire [3:0] idx_high;
  wire [3:0] idx_low;
  wire global_irq_enable;
  wire converter_irq_enable;
  wire timer_two_irq_enable;
  wire uart_irq_enable;
  wire timer_one_irq_enable;
  wire ext_one_irq_enable;
  wire timer_zero_irq_enable;
  wire ext_zero_irq_enable;
  wire interval_counter_irq_enable;
  wire supply_monitor_irq_enable;
  wire serial_port_irq_enable;
  wire converter_priority;
  wire timer_two_priority;
  wire uart_priority;
  wire timer_one_priority;
  wire ext_one_priority;
  wire timer_zero_priority;
  wire ext_zero_priority;
  wire interval_counter_priority;
  wire supply_monitor_priority;
  wire serial_port_priority;

  // Masked write keeps fixed bits at their reset value
  function [7:0] masked_write;
    input [7:0] old_val;
    input [7:0] new_val;
    input [7:0] wmask;
    begin
      masked_write = (old_val & ~wmask) | (new_val & wmask);
    end
  endfunction

  // Bit write into a bit addressable register
  function [7:0] bit_write;
    input [7:0] old_val;
    input [2:0] pos;
    input val;
    input [7:0] wmask;
    reg [7:0] sel;
    begin
      sel = 8'h01 << pos;
      bit_write = masked_write(old_val, val ? sel : 8'h00, sel);
      bit_write = (bit_write & wmask) | (old_val & ~wmask);
    end
  endfunction

  function [15:0] vector_of;
    input [3:0] idx;
    begin
      case (idx)
        `TLIC_SRC_PSM: vector_of = `TLIC_VEC_PSM;
        `TLIC_SRC_WDOG: vector_of = `TLIC_VEC_WDOG;
        `TLIC_SRC_EXT0: vector_of = `TLIC_VEC_EXT0;
        `TLIC_SRC_ADC: vector_of = `TLIC_VEC_ADC;
        `TLIC_SRC_TIMER0: vector_of = `TLIC_VEC_TIMER0;
        `TLIC_SRC_EXT1: vector_of = `TLIC_VEC_EXT1;
        `TLIC_SRC_TIMER1: vector_of = `TLIC_VEC_TIMER1;
        `TLIC_SRC_SPI: vector_of = `TLIC_VEC_SPI;
        `TLIC_SRC_UART: vector_of = `TLIC_VEC_UART;
        `TLIC_SRC_TIMER2: vector_of = `TLIC_VEC_TIMER2;
        default: vector_of = `TLIC_VEC_TIC;
      endcase
    end
  endfunction

  // Field extraction
  assign global_irq_enable = interrupt_enable_primary[`TLIC_BIT_GLOBAL_IRQ_ENABLE];
  assign converter_irq_enable = interrupt_enable_primary[`TLIC_BIT_CONVERTER_IRQ_ENABLE];
  assign timer_two_irq_enable = interrupt_enable_primary[`TLIC_BIT_TIMER_TWO_IRQ_ENABLE];
  assign uart_irq_enable = interrupt_enable_primary[`TLIC_BIT_UART_IRQ_ENABLE];
  assign timer_one_irq_enable = interrupt_enable_primary[`TLIC_BIT_TIMER_ONE_IRQ_ENABLE];
  assign ext_one_irq_enable = interrupt_enable_primary[`TLIC_BIT_EXT_ONE_IRQ_ENABLE];
  assign timer_zero_irq_enable = interrupt_enable_primary[`TLIC_BIT_TIMER_ZERO_IRQ_ENABLE];
  assign ext_zero_irq_enable = interrupt_enable_primary[`TLIC_BIT_EXT_ZERO_IRQ_ENABLE];
  assign interval_counter_irq_enable =
    interrupt_enable_priority_secondary[`TLIC_BIT_INTERVAL_COUNTER_IRQ_ENABLE];
  assign supply_monitor_irq_enable =
    interrupt_enable_priority_secondary[`TLIC_BIT_SUPPLY_MONITOR_IRQ_ENABLE];
  assign serial_port_irq_enable =
    interrupt_enable_priority_secondary[`TLIC_BIT_SERIAL_PORT_IRQ_ENABLE];
  assign converter_priority = interrupt_priority_primary[`TLIC_BIT_CONVERTER_PRIORITY];
  assign timer_two_priority = interrupt_priority_primary[`TLIC_BIT_TIMER_TWO_PRIORITY];
  assign uart_priority = interrupt_priority_primary[`TLIC_BIT_UART_PRIORITY];
  assign timer_one_priority = interrupt_priority_primary[`TLIC_BIT_TIMER_ONE_PRIORITY];
  assign ext_one_priority = interrupt_priority_primary[`TLIC_BIT_EXT_ONE_PRIORITY];
  assign timer_zero_priority = interrupt_priority_primary[`TLIC_BIT_TIMER_ZERO_PRIORITY];
  assign ext_zero_priority = interrupt_priority_primary[`TLIC_BIT_EXT_ZERO_PRIORITY];
  assign interval_counter_priority =
    interrupt_enable_priority_secondary[`TLIC_BIT_INTERVAL_COUNTER_PRIORITY];
  assign supply_monitor_priority =
    interrupt_enable_priority_secondary[`TLIC_BIT_SUPPLY_MONITOR_PRIORITY];
  assign serial_port_priority =
    interrupt_enable_priority_secondary[`TLIC_BIT_SERIAL_PORT_PRIORITY];

  // Requests in polling order
  assign req_in = {src_tic_req, src_timer2_req, src_uart_req, src_spi_req,
                   src_timer1_req, src_ext1_req, src_timer0_req, src_adc_req,
                   src_ext0_req, src_wdog_req, src_psm_req};

  // Watchdog has no enable bit here; it rides the master enable only
  assign src_enable = {interval_counter_irq_enable,
                       timer_two_irq_enable,
                       uart_irq_enable,
                       serial_port_irq_enable,
                       timer_one_irq_enable,
                       ext_one_irq_enable,
                       timer_zero_irq_enable,
                       converter_irq_enable,
                       ext_zero_irq_enable,
                       1'b1,
                       supply_monitor_irq_enable};

  // Watchdog always treated as high level
  assign src_high = {interval_counter_priority,
                     timer_two_priority,
                     uart_priority,
                     serial_port_priority,
                     timer_one_priority,
                     ext_one_priority,
                     timer_zero_priority,
                     converter_priority,
                     ext_zero_priority,
                     1'b1,
                     supply_monitor_priority};

  assign pending = req_in & src_enable & {`TLIC_NUM_SRC{global_irq_enable}};
  assign cand_high = pending & src_high;
  assign cand_low = pending & ~src_high;

  tlic_pick #(
    .N(`TLIC_NUM_SRC)
  ) u_pick_high (
    .cand(cand_high),
    .found(found_high),
    .idx(idx_high)
  );

  tlic_pick #(
    .N(`TLIC_NUM_SRC)
  ) u_pick_low (
    .cand(cand_low),
    .found(found_low),
    .idx(idx_low)
  );

  // Register writes; byte write wins over a bit write in the same cycle
  always @* begin
    next_enable_primary = interrupt_enable_primary;
    next_enable_priority_secondary = interrupt_enable_priority_secondary;
    next_priority_primary = interrupt_priority_primary;
    if (sfr_bit_wr) begin
      if ({sfr_bit_addr[7:3], 3'b000} == `TLIC_ADDR_ENABLE_PRIMARY) begin
        next_enable_primary = bit_write(interrupt_enable_primary, sfr_bit_addr[2:0],
                                        sfr_bit_wdata, `TLIC_WMASK_ENABLE_PRIMARY);
      end else if ({sfr_bit_addr[7:3], 3'b000} == `TLIC_ADDR_PRIORITY_PRIMARY) begin
        next_priority_primary = bit_write(interrupt_priority_primary, sfr_bit_addr[2:0],
                                          sfr_bit_wdata, `TLIC_WMASK_PRIORITY_PRIMARY);
      end
    end
    if (sfr_wr) begin
      if (sfr_addr == `TLIC_ADDR_ENABLE_PRIMARY) begin
        next_enable_primary = masked_write(interrupt_enable_primary, sfr_wdata,
                                           `TLIC_WMASK_ENABLE_PRIMARY);
      end else if (sfr_addr == `TLIC_ADDR_ENABLE_PRIORITY_SECONDARY) begin
        next_enable_priority_secondary = masked_write(interrupt_enable_priority_secondary,
          sfr_wdata, `TLIC_WMASK_ENABLE_PRIORITY_SECONDARY);
      end else if (sfr_addr == `TLIC_ADDR_PRIORITY_PRIMARY) begin
        next_priority_primary = masked_write(interrupt_priority_primary, sfr_wdata,
                                             `TLIC_WMASK_PRIORITY_PRIMARY);
      end
    end
  end

  // Read data, registered; unmapped addresses read zero
  always @* begin
    next_rdata = sfr_rdata;
    if (sfr_rd) begin
      if (sfr_addr == `TLIC_ADDR_ENABLE_PRIMARY) begin
        next_rdata = interrupt_enable_primary;
      end else if (sfr_addr == `TLIC_ADDR_ENABLE_PRIORITY_SECONDARY) begin
        next_rdata = interrupt_enable_priority_secondary;
      end else if (sfr_addr == `TLIC_ADDR_PRIORITY_PRIMARY) begin
        next_rdata = interrupt_priority_primary;
      end else begin
        next_rdata = 8'h00;
      end
    end
  end

  // In-service levels; return retires the highest active level first
  always @* begin
    next_active_high = active_high;
    next_active_low = active_low;
    if (irq_return) begin
      if (active_high) begin
        next_active_high = 1'b0;
      end else begin
        next_active_low = 1'b0;
      end
    end
    if (irq_ack && irq_valid) begin
      if (irq_level) begin
        next_active_high = 1'b1;
      end else begin
        next_active_low = 1'b1;
      end
    end
  end

  // Request selection toward the core
  always @* begin
    next_valid = 1'b0;
    next_vector = irq_vector;
    next_level = irq_level;
    next_source = irq_source;
    // Drop for one cycle after acceptance so the same request is not offered twice
    if (irq_ack && irq_valid) begin
      next_valid = 1'b0;
    end else if (active_high) begin
      next_valid = 1'b0;
    end else if (found_high) begin
      next_valid = 1'b1;
      next_level = 1'b1;
      next_source = idx_high;
      next_vector = vector_of(idx_high);
    end else if (found_low && !active_low) begin
      next_valid = 1'b1;
      next_level = 1'b0;
      next_source = idx_low;
      next_vector = vector_of(idx_low);
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      interrupt_enable_primary <= `TLIC_RST_ENABLE_PRIMARY;
      interrupt_enable_priority_secondary <= `TLIC_RST_ENABLE_PRIORITY_SECONDARY;
      interrupt_priority_primary <= `TLIC_RST_PRIORITY_PRIMARY;
      sfr_rdata <= 8'h00;
      irq_valid <= 1'b0;
      irq_vector <= 16'h0000;
      irq_level <= 1'b0;
      irq_source <= 4'h0;
      active_high <= 1'b0;
      active_low <= 1'b0;
    end else begin
      interrupt_enable_primary <= next_enable_primary;
      interrupt_enable_priority_secondary <= next_enable_priority_secondary;
      interrupt_priority_primary <= next_priority_primary;
      sfr_rdata <= next_rdata;
      irq_valid <= next_valid;
      irq_vector <= next_vector;
      irq_level <= next_level;
      irq_source <= next_source;
      active_high <= next_active_high;
      active_low <= next_active_low;
    end
  end

endmodule // tlic_ctrl

`default_nettype wire

// file: design/tlic_pick.v
`timescale 1ns/100ps
`default_nettype none

// Fixed polling order: lowest index wins
module tlic_pick #(
  parameter N = 11
) (
  input wire [N-1:0] cand,
  output reg found,
  output reg [3:0] idx
);

  integer i;

  always @* begin
    found = 1'b0;
    idx = 4'h0;
    for (i = N - 1; i >= 0; i = i - 1) begin
      if (cand[i]) begin
        found = 1'b1;
        idx = i[3:0];
      end
    end
  end

endmodule // tlic_pick

`default_nettype wire

// file: design/tlic_regs.vh
`ifndef TLIC_REGS_VH
`define TLIC_REGS_VH

// Special function register addresses
`define TLIC_ADDR_ENABLE_PRIMARY 8'ha8
`define TLIC_ADDR_ENABLE_PRIORITY_SECONDARY 8'ha9
`define TLIC_ADDR_PRIORITY_PRIMARY 8'hb8

// Reset values
`define TLIC_RST_ENABLE_PRIMARY 8'h00
`define TLIC_RST_ENABLE_PRIORITY_SECONDARY 8'ha0
`define TLIC_RST_PRIORITY_PRIMARY 8'h00

// Writable bits; other bits keep their fixed value
`define TLIC_WMASK_ENABLE_PRIMARY 8'hff
`define TLIC_WMASK_ENABLE_PRIORITY_SECONDARY 8'h77
`define TLIC_WMASK_PRIORITY_PRIMARY 8'h7f

// Primary enable fields
`define TLIC_BIT_GLOBAL_IRQ_ENABLE 7
`define TLIC_BIT_CONVERTER_IRQ_ENABLE 6
`define TLIC_BIT_TIMER_TWO_IRQ_ENABLE 5
`define TLIC_BIT_UART_IRQ_ENABLE 4
`define TLIC_BIT_TIMER_ONE_IRQ_ENABLE 3
`define TLIC_BIT_EXT_ONE_IRQ_ENABLE 2
`define TLIC_BIT_TIMER_ZERO_IRQ_ENABLE 1
`define TLIC_BIT_EXT_ZERO_IRQ_ENABLE 0

// Primary priority fields
`define TLIC_BIT_CONVERTER_PRIORITY 6
`define TLIC_BIT_TIMER_TWO_PRIORITY 5
`define TLIC_BIT_UART_PRIORITY 4
`define TLIC_BIT_TIMER_ONE_PRIORITY 3
`define TLIC_BIT_EXT_ONE_PRIORITY 2
`define TLIC_BIT_TIMER_ZERO_PRIORITY 1
`define TLIC_BIT_EXT_ZERO_PRIORITY 0

// Secondary enable and priority fields
`define TLIC_BIT_INTERVAL_COUNTER_PRIORITY 6
`define TLIC_BIT_SUPPLY_MONITOR_PRIORITY 5
`define TLIC_BIT_SERIAL_PORT_PRIORITY 4
`define TLIC_BIT_SECONDARY_ZERO 3
`define TLIC_BIT_INTERVAL_COUNTER_IRQ_ENABLE 2
`define TLIC_BIT_SUPPLY_MONITOR_IRQ_ENABLE 1
`define TLIC_BIT_SERIAL_PORT_IRQ_ENABLE 0

// Source index in polling order, 0 polled first
`define TLIC_NUM_SRC 11
`define TLIC_SRC_PSM 4'h0
`define TLIC_SRC_WDOG 4'h1
`define TLIC_SRC_EXT0 4'h2
`define TLIC_SRC_ADC 4'h3
`define TLIC_SRC_TIMER0 4'h4
`define TLIC_SRC_EXT1 4'h5
`define TLIC_SRC_TIMER1 4'h6
`define TLIC_SRC_SPI 4'h7
`define TLIC_SRC_UART 4'h8
`define TLIC_SRC_TIMER2 4'h9
`define TLIC_SRC_TIC 4'ha

// Vector addresses
`define TLIC_VEC_EXT0 16'h0003
`define TLIC_VEC_TIMER0 16'h000b
`define TLIC_VEC_EXT1 16'h0013
`define TLIC_VEC_TIMER1 16'h001b
`define TLIC_VEC_UART 16'h0023
`define TLIC_VEC_TIMER2 16'h002b
`define TLIC_VEC_ADC 16'h0033
`define TLIC_VEC_SPI 16'h003b
`define TLIC_VEC_PSM 16'h0043
`define TLIC_VEC_TIC 16'h0053
`define TLIC_VEC_WDOG 16'h005b

`endif

// file: verification/tlic_core_model.sv
`timescale 1ns/100ps
`default_nettype none
module tlic_core_model #(
  parameter int SVC = 4
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic irq_valid,
  input wire logic [15:0] irq_vector,
  input wire logic irq_level,
  input wire logic stall,
  input wire logic hold,
  output logic irq_ack,
  output logic irq_return,
  output logic [15:0] last_vector,
  output logic last_level,
  output logic [7:0] n_acks
);
  logic [1:0] depth;
  int timer;
  // Vector and level taken at the accepting edge
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      last_vector <= 16'h0000;
      last_level <= 1'b0;
      n_acks <= 8'h00;
    end else if (irq_ack && irq_valid) begin
      last_vector <= irq_vector;
      last_level <= irq_level;
      n_acks <= n_acks + 8'h01;
    end
  end
  // Nested routines return newest first; hold keeps a routine running
  always @(negedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_ack <= 1'b0;
      irq_return <= 1'b0;
      depth <= 2'h0;
      timer <= 0;
    end else begin
      irq_ack <= 1'b0;
      irq_return <= 1'b0;
      if (irq_valid && !irq_ack && !stall) begin
        irq_ack <= 1'b1;
        depth <= depth + 2'h1;
        timer <= SVC;
      end else if (depth != 2'h0 && !hold) begin
        if (timer == 0) begin
          irq_return <= 1'b1;
          depth <= depth - 2'h1;
          timer <= SVC;
        end else begin
          timer <= timer - 1;
        end
      end
    end
  end
endmodule // tlic_core_model
`default_nettype wire

// file: verification/tlic_ctrl_chk.sv
`timescale 1ns/100ps
`default_nettype none
module tlic_chk (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic sfr_bit_wr,
  input wire logic [7:0] sfr_bit_addr,
  input wire logic sfr_bit_wdata,
  input wire logic irq_ack,
  input wire logic irq_return,
  input wire logic irq_valid,
  input wire logic [15:0] irq_vector,
  input wire logic irq_level,
  input wire logic [3:0] irq_source,
  input wire logic active_high,
  input wire logic active_low
);
  // Shadows of what software wrote; the design is never peeked into
  logic [7:0] ie_sh, ip_sh, sec_sh;
  logic [10:0] en_q, pr_q;
  wire logic [10:0] en_vec;
  wire logic [10:0] pr_vec;
  logic [15:0] vec_of [0:10] = '{16'h0043, 16'h005b, 16'h0003, 16'h0033, 16'h000b, 16'h0013,
    16'h001b, 16'h003b, 16'h0023, 16'h002b, 16'h0053};
  assign en_vec = {sec_sh[2], ie_sh[5], ie_sh[4], sec_sh[0], ie_sh[3:1], ie_sh[6], ie_sh[0], 1'b1,
    sec_sh[1]} & {11{ie_sh[7]}};
  assign pr_vec = {sec_sh[6], ip_sh[5], ip_sh[4], sec_sh[4], ip_sh[3:1], ip_sh[6], ip_sh[0], 1'b1,
    sec_sh[5]};
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ie_sh <= 8'h00;
      ip_sh <= 8'h00;
      sec_sh <= 8'ha0;
      en_q <= 11'h000;
      pr_q <= 11'h000;
    end else begin
      en_q <= en_vec;
      pr_q <= pr_vec;
      if (sfr_wr && sfr_addr == 8'ha8) begin
        ie_sh <= sfr_wdata;
      end else if (sfr_bit_wr && sfr_bit_addr[7:3] == 5'h15) begin
        ie_sh[sfr_bit_addr[2:0]] <= sfr_bit_wdata;
      end
      if (sfr_wr && sfr_addr == 8'hb8) begin
        ip_sh <= sfr_wdata;
      end else if (sfr_bit_wr && sfr_bit_addr[7:3] == 5'h17) begin
        ip_sh[sfr_bit_addr[2:0]] <= sfr_bit_wdata;
      end
      if (sfr_wr && sfr_addr == 8'ha9) sec_sh <= sfr_wdata;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_unmapped;
    sfr_rd && !(sfr_addr inside {8'ha8, 8'ha9, 8'hb8}) |=> sfr_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_rd_ie;
    sfr_rd && sfr_addr == 8'ha8 |=> sfr_rdata == $past(ie_sh);
  endproperty
  a_rd_ie: assert property (p_rd_ie) else $error("enable read mismatch");
  property p_master;
    irq_valid |-> $past(ie_sh[7]);
  endproperty
  a_master: assert property (p_master) else $error("offer without master enable");
  property p_enabled;
    irq_valid |-> en_q[irq_source];
  endproperty
  a_enabled: assert property (p_enabled) else $error("offer of disabled source");
  property p_level;
    irq_valid |-> irq_level == pr_q[irq_source];
  endproperty
  a_level: assert property (p_level) else $error("offered level wrong");
  property p_vector;
    irq_valid |-> irq_vector == vec_of[irq_source];
  endproperty
  a_vector: assert property (p_vector) else $error("vector wrong");
  property p_ack_high;
    irq_valid && irq_ack && irq_level && !irq_return |=> active_high ##0 !irq_valid;
  endproperty
  a_ack_high: assert property (p_ack_high) else $error("high accept not in service");
  property p_high_blocks;
    active_high |-> !irq_valid;
  endproperty
  a_high_blocks: assert property (p_high_blocks) else $error("offer during high service");
  property p_low_blocks;
    active_low && irq_valid |-> irq_level;
  endproperty
  a_low_blocks: assert property (p_low_blocks) else $error("low offer during low service");
  c_high_ack: cover property (irq_valid && irq_ack && irq_level);
  c_nested: cover property (active_high && active_low);
  c_unmapped: cover property (sfr_rd && sfr_addr == 8'ha7);
endmodule // tlic_chk
bind tlic_ctrl tlic_chk tlic_chk_i (.*);
`default_nettype wire

// file: verification/tlic_ctrl_test.sv
`timescale 1ns/100ps
`default_nettype none
module tlic_ctrl_test;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic sfr_wr = 1'b0, sfr_rd = 1'b0, sfr_bit_wr = 1'b0, sfr_bit_wdata = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_bit_addr = 8'h00, sfr_rdata, n_acks;
  logic [10:0] src = 11'h000;
  logic stall = 1'b1, hold = 1'b1;
  logic irq_ack, irq_return, irq_valid, irq_level, active_high, active_low, last_level;
  logic [15:0] irq_vector, last_vector;
  logic [3:0] irq_source;
  int n_errors = 0, tests_run = 0, cycles = 0;
  // Enable bit per polling index; wdog entry unused
  int ebit [0:10] = '{1, 0, 0, 6, 1, 2, 3, 0, 4, 5, 2};
  logic [10:0] in_sec = 11'h481;
  logic [15:0] vec [0:10] = '{16'h0043, 16'h005b, 16'h0003, 16'h0033, 16'h000b, 16'h0013,
    16'h001b, 16'h003b, 16'h0023, 16'h002b, 16'h0053};
  tlic_ctrl tlic_ctrl_i (.clk(clk), .rstn(rstn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .sfr_bit_wr(sfr_bit_wr),
    .sfr_bit_addr(sfr_bit_addr), .sfr_bit_wdata(sfr_bit_wdata), .src_psm_req(src[0]),
    .src_wdog_req(src[1]), .src_ext0_req(src[2]), .src_adc_req(src[3]), .src_timer0_req(src[4]),
    .src_ext1_req(src[5]), .src_timer1_req(src[6]), .src_spi_req(src[7]), .src_uart_req(src[8]),
    .src_timer2_req(src[9]), .src_tic_req(src[10]), .irq_ack(irq_ack), .irq_return(irq_return),
    .irq_valid(irq_valid), .irq_vector(irq_vector), .irq_level(irq_level),
    .irq_source(irq_source), .active_high(active_high), .active_low(active_low));
  tlic_core_model tlic_core_model_i (.clk(clk), .rstn(rstn), .irq_valid(irq_valid),
    .irq_vector(irq_vector), .irq_level(irq_level), .stall(stall), .hold(hold),
    .irq_ack(irq_ack), .irq_return(irq_return), .last_vector(last_vector),
    .last_level(last_level), .n_acks(n_acks));
  always #2.5 clk = ~clk;
  task automatic conclude;
    if (n_errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors = n_errors + 1;
      conclude();
    end
  end
  task automatic chkv(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask
  task automatic bwr(input logic [7:0] a, input logic v);
    @(negedge clk);
    sfr_bit_addr = a;
    sfr_bit_wdata = v;
    sfr_bit_wr = 1'b1;
    @(negedge clk);
    sfr_bit_wr = 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    chkv({8'h00, sfr_rdata}, {8'h00, exp});
  endtask
  task automatic wait_acks(input logic [7:0] k);
    repeat (60) if (n_acks !== k) @(negedge clk);
    chkv({8'h00, n_acks}, {8'h00, k});
  endtask
  initial begin
    logic [7:0] en;
    tick(5);
    rstn = 1'b1;
    rdc(8'ha8, 8'h00);
    rdc(8'ha9, 8'ha0);
    rdc(8'hb8, 8'h00);
    rdc(8'ha7, 8'h00);
    wr(8'hb8, 8'hff);
    rdc(8'hb8, 8'h7f);
    wr(8'ha9, 8'h77);
    rdc(8'ha9, 8'hf7);
    wr(8'ha9, 8'h00);
    rdc(8'ha9, 8'h80);
    wr(8'hb8, 8'h00);
    // Bit writes into the priority and enable registers, unimplemented bit included
    bwr(8'hbf, 1'b1);
    bwr(8'hbc, 1'b1);
    rdc(8'hb8, 8'h10);
    wr(8'hb8, 8'h00);
    bwr(8'haf, 1'b1);
    rdc(8'ha8, 8'h80);
    // Each source alone: offer, level, master gate, own enable
    for (int s = 0; s < 11; s++) if (s != 1) begin
      en = 8'h01 << ebit[s];
      wr(8'ha8, in_sec[s] ? 8'h80 : 8'h80 | en);
      wr(8'ha9, in_sec[s] ? en : 8'h00);
      src[s] = 1'b1;
      tick(3);
      chkv({15'h0, irq_valid}, 16'h1);
      chkv(irq_vector, vec[s]);
      chkv({12'h0, irq_source}, 16'(s));
      chkv({15'h0, irq_level}, 16'h0);
      if (in_sec[s]) wr(8'ha9, en | (en << 4));
      else wr(8'hb8, en);
      tick(2);
      chkv({15'h0, irq_level}, 16'h1);
      wr(8'ha8, in_sec[s] ? 8'h00 : en);
      tick(2);
      chkv({15'h0, irq_valid}, 16'h0);
      wr(8'ha8, 8'h80);
      wr(8'ha9, 8'h00);
      tick(2);
      chkv({15'h0, irq_valid}, 16'h0);
      src[s] = 1'b0;
      wr(8'hb8, 8'h00);
    end
    src[1] = 1'b1;
    tick(3);
    chkv(irq_vector, 16'h005b);
    wr(8'ha8, 8'h00);
    tick(2);
    chkv({15'h0, irq_valid}, 16'h0);
    src[1] = 1'b0;
    // Same level, all at once: drained in polling order
    wr(8'ha8, 8'hff);
    wr(8'ha9, 8'h07);
    src = 11'h7fd;
    for (int s = 0; s < 11; s++) if (s != 1) begin
      tick(2);
      chkv({12'h0, irq_source}, 16'(s));
      src[s] = 1'b0;
    end
    // Levels against the core: high first, no same-level nesting, preemption
    wr(8'ha8, 8'h93);
    wr(8'ha9, 8'h00);
    wr(8'hb8, 8'h10);
    stall <= 1'b0;
    src[2] = 1'b1;
    src[8] = 1'b1;
    wait_acks(8'h01);
    chkv(last_vector, 16'h0023);
    src[8] = 1'b0;
    tick(6);
    chkv({8'h00, n_acks}, 16'h0001);
    hold <= 1'b0;
    wait_acks(8'h02);
    hold <= 1'b1;
    chkv(last_vector, 16'h0003);
    src[2] = 1'b0;
    src[4] = 1'b1;
    tick(6);
    chkv({8'h00, n_acks}, 16'h0002);
    src[8] = 1'b1;
    wait_acks(8'h03);
    chkv({14'h0, active_high, active_low}, 16'h3);
    src = 11'h000;
    hold <= 1'b0;
    tick(30);
    chkv({14'h0, active_high, active_low}, 16'h0);
    conclude();
  end
endmodule // tlic_ctrl_test
`default_nettype wire
